// ===== logic/bis_pkg.sv
// constants and types for the binary input switch sensor
package bis_pkg;

  // time base
  localparam int CLK_HZ     = 50_000_000;
  localparam int MS_PER_S   = 1000;
  localparam int MS_CYC     = CLK_HZ / MS_PER_S;
  localparam int DEC_MS     = 100;
  localparam int SEC_DEC    = 10;

  // debounce choices in ms
  localparam logic [7:0] DEB_10  = 8'h0A;
  localparam logic [7:0] DEB_20  = 8'h14;
  localparam logic [7:0] DEB_30  = 8'h1E;
  localparam logic [7:0] DEB_50  = 8'h32;
  localparam logic [7:0] DEB_70  = 8'h46;
  localparam logic [7:0] DEB_100 = 8'h64;
  localparam logic [7:0] DEB_150 = 8'h96;

  // configuration defaults, for the integrator
  localparam logic [15:0] MIN_SIG_DEF   = 16'h000A;
  localparam logic [14:0] WAIT_DEF      = 15'h0000;
  localparam logic [14:0] WAIT_MAX      = 15'h7530;
  localparam logic [15:0] CYC_DEF       = 16'h003C;
  localparam logic [2:0]  DEB_SEL_DEF   = 3'h3;

  // reaction codes; OFF is the default
  typedef enum logic [2:0] {
    RX_ON   = 3'h0,
    RX_OFF  = 3'h1,
    RX_TOG  = 3'h2,
    RX_NONE = 3'h3,
    RX_TERM = 3'h4
  } bis_react_e;

  // value filter for cyclic sending
  localparam logic [1:0] CYV_ONE  = 2'h0;
  localparam logic [1:0] CYV_ZERO = 2'h1;
  localparam logic [1:0] CYV_BOTH = 2'h2;

  // internal connection selector
  localparam logic [4:0] LINK_NONE      = 5'h00;
  localparam logic [4:0] LINK_OUT_FIRST = 5'h01;
  localparam logic [4:0] LINK_OUT_LAST  = 5'h10;
  localparam logic [4:0] LINK_SCN_FIRST = 5'h11;
  localparam logic [4:0] LINK_SCN_LAST  = 5'h18;

  // press classifier, gray along idle -> held -> long
  typedef enum logic [1:0] {
    PR_IDLE = 2'b00,
    PR_HELD = 2'b01,
    PR_LONG = 2'b11
  } bis_press_e;

  function automatic logic [7:0] deb_ms(input logic [2:0] sel);
    case (sel)
      3'h0: deb_ms = DEB_10;
      3'h1: deb_ms = DEB_20;
      3'h2: deb_ms = DEB_30;
      3'h3: deb_ms = DEB_50;
      3'h4: deb_ms = DEB_70;
      3'h5: deb_ms = DEB_100;
      default: deb_ms = DEB_150;
    endcase
  endfunction

endpackage

// ===== logic/bis_switch_sensor.sv
// switch sensor processing chain for one contact-scanning binary input
// Functional notes
// - asserted enabled block ignores physical contact
// - cyclic sending continues while input blocked
// - block ignored when internal blocking disallowed
// - injected bus value acts as contact event
// - edge reacts at once, starts debounce
// - edges ignored during debounce period
// - long/short mode defers reaction until classified
// - plain mode: open event 0, close 1
// - separate close/open minimum times, 0.1 s
// - edge starts minimum timer, no send
// - edge during minimum timer restarts it
// - minimum timer expiry sends edge telegram
// - rescan after download, reset, recovery if enabled
// - recovery waits configured seconds, then rescans
// - wait timed apart from send delay
// - reaction ON, OFF, TOGGLE, none, stop cycle
// - reaction fires on press or edge
// - stop-cycle only acts with cyclic enabled
// - linked output or scenario pair updated too
// - scenario: 0 odd, 1 even number
// - linked toggle uses inverted output status
// - send on change, on recovery only with cyclic enabled; restart cycle timer
// - short press event 0, long event 1
`timescale 1ns/1ps

module bis_switch_sensor #(
  parameter int TICK_MS_CYC = bis_pkg::MS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        contact_in,
  input  wire logic        int_block_en,
  input  wire logic        block_obj_en,
  input  wire logic        block_obj,
  input  wire logic        inject_en,
  input  wire logic        inject_valid,
  input  wire logic        inject_value,
  input  wire logic [2:0]  debounce_sel,
  input  wire logic        long_en,
  input  wire logic [7:0]  long_time,
  input  wire logic        min_sig_en,
  input  wire logic [15:0] min_close_time,
  input  wire logic [15:0] min_open_time,
  input  wire logic        rescan_en,
  input  wire logic [14:0] wait_time,
  input  wire logic        download_evt,
  input  wire logic        bus_reset_evt,
  input  wire logic        bus_recover_evt,
  input  wire logic [2:0]  react0,
  input  wire logic [2:0]  react1,
  input  wire logic        cyc_en,
  input  wire logic [15:0] cyc_period,
  input  wire logic [1:0]  cyc_value_sel,
  input  wire logic [4:0]  link_sel,
  input  wire logic        link_status,
  output logic             switch_val,
  output logic             send_pulse,
  output logic             event_pulse,
  output logic             event_id,
  output logic             out_update,
  output logic [3:0]       out_index,
  output logic             out_value,
  output logic             scen_trig,
  output logic [4:0]       scen_num
);

  localparam int MSW = $clog2(TICK_MS_CYC + 1);

  // common time base: ms, 100 ms and 1 s ticks
  logic [MSW-1:0] ms_cnt_q;
  logic [6:0]     dec_cnt_q;
  logic [3:0]     sec_cnt_q;
  logic           tick_ms;
  logic           tick_dec;
  logic           tick_s;

  assign tick_ms  = (ms_cnt_q == MSW'(TICK_MS_CYC - 1));
  assign tick_dec = tick_ms && (dec_cnt_q == 7'(bis_pkg::DEC_MS - 1));
  assign tick_s   = tick_dec && (sec_cnt_q == 4'(bis_pkg::SEC_DEC - 1));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_cnt_q  <= '0;
      dec_cnt_q <= '0;
      sec_cnt_q <= '0;
    end else begin
      ms_cnt_q <= tick_ms ? '0 : ms_cnt_q + MSW'(1);
      if (tick_ms) begin
        dec_cnt_q <= tick_dec ? '0 : dec_cnt_q + 7'h01;
      end
      if (tick_dec) begin
        sec_cnt_q <= tick_s ? '0 : sec_cnt_q + 4'h1;
      end
    end
  end

  // blocking only counts when enabled and permitted
  logic block_act;
  assign block_act = int_block_en && block_obj_en && block_obj;

  // rescan and recovery wait
  logic        wait_act_q;
  logic [14:0] wait_cnt_q;
  logic        wait_done;
  logic        scan_now;

  assign wait_done = wait_act_q && (wait_cnt_q == '0);
  // a blocked input is not sampled either
  assign scan_now  = !block_act &&
                     ((rescan_en && (download_evt || bus_reset_evt)) || wait_done);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_act_q <= 1'b0;
      wait_cnt_q <= '0;
    end else if (rescan_en && bus_recover_evt) begin
      wait_act_q <= 1'b1;
      wait_cnt_q <= wait_time;
    end else if (wait_done) begin
      wait_act_q <= 1'b0;
    end else if (wait_act_q && tick_s) begin
      // own counter, never summed with a send delay
      wait_cnt_q <= wait_cnt_q - 15'h0001;
    end
  end

  // debounce: react on the edge, then go deaf for the period
  logic       stable_q;
  logic [7:0] deb_cnt_q;
  logic       phys_edge;
  logic       edge_v;

  assign phys_edge = !block_act && (deb_cnt_q == '0) && (contact_in != stable_q);
  assign edge_v    = phys_edge || scan_now;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stable_q  <= 1'b0;
      deb_cnt_q <= '0;
    end else begin
      if (edge_v) begin
        stable_q <= contact_in;
      end
      if (phys_edge) begin
        deb_cnt_q <= bis_pkg::deb_ms(debounce_sel);
      end else if (deb_cnt_q != '0 && tick_ms) begin
        deb_cnt_q <= deb_cnt_q - 8'h01;
      end
    end
  end

  // minimum signal time
  logic        ms_act_q;
  logic        ms_lvl_q;
  logic [15:0] min_cnt_q;
  logic        ms_fire;
  logic        qual_v;
  logic        qual_lvl;

  assign ms_fire  = ms_act_q && (min_cnt_q == '0) && !edge_v;
  assign qual_v   = min_sig_en ? ms_fire : edge_v;
  assign qual_lvl = min_sig_en ? ms_lvl_q : contact_in;

  always_ff @(posedge sys_clk) begin
    if (reset || !min_sig_en) begin
      ms_act_q  <= 1'b0;
      ms_lvl_q  <= 1'b0;
      min_cnt_q <= '0;
    end else if (edge_v) begin
      // a new edge is a new operation
      ms_act_q  <= 1'b1;
      ms_lvl_q  <= contact_in;
      min_cnt_q <= contact_in ? min_close_time : min_open_time;
    end else if (ms_fire) begin
      ms_act_q <= 1'b0;
    end else if (ms_act_q && tick_dec) begin
      min_cnt_q <= min_cnt_q - 16'h0001;
    end
  end

  // short/long classifier; closed contact is a press
  bis_pkg::bis_press_e pr_q;
  logic [8:0]          lt_cnt_q;
  logic                pr_short;
  logic                pr_long;

  assign pr_short = (pr_q == bis_pkg::PR_HELD) && qual_v && !qual_lvl;
  assign pr_long  = (pr_q == bis_pkg::PR_HELD) && !pr_short &&
                    (lt_cnt_q > {1'b0, long_time});

  always_ff @(posedge sys_clk) begin
    if (reset || !long_en) begin
      pr_q     <= bis_pkg::PR_IDLE;
      lt_cnt_q <= '0;
    end else begin
      case (pr_q)
        bis_pkg::PR_IDLE: begin
          if (qual_v && qual_lvl) begin
            pr_q     <= bis_pkg::PR_HELD;
            lt_cnt_q <= '0;
          end
        end
        bis_pkg::PR_HELD: begin
          if (pr_short) begin
            pr_q <= bis_pkg::PR_IDLE;
          end else if (pr_long) begin
            pr_q <= bis_pkg::PR_LONG;
          end else if (tick_dec) begin
            lt_cnt_q <= lt_cnt_q + 9'h001;
          end
        end
        bis_pkg::PR_LONG: begin
          if (qual_v && !qual_lvl) begin
            pr_q <= bis_pkg::PR_IDLE;
          end
        end
        default: pr_q <= bis_pkg::PR_IDLE;
      endcase
    end
  end

  // event source selection
  logic inj_v;
  logic ev_v;
  logic ev_id;

  assign inj_v = inject_en && inject_valid && !block_act;

  always_comb begin
    ev_v  = 1'b0;
    ev_id = 1'b0;
    if (inj_v) begin
      ev_v  = 1'b1;
      ev_id = inject_value;
    end else if (!long_en) begin
      ev_v  = qual_v;
      ev_id = qual_lvl;
    end else if (pr_short || pr_long) begin
      ev_v  = 1'b1;
      ev_id = pr_long;
    end
  end

  // reaction on the first switch object
  logic [2:0] rx;
  logic       link_out;
  logic       link_scn;
  logic       upd;
  logic       new_val;

  assign rx       = ev_id ? react1 : react0;
  assign link_out = (link_sel >= bis_pkg::LINK_OUT_FIRST) &&
                    (link_sel <= bis_pkg::LINK_OUT_LAST);
  assign link_scn = (link_sel >= bis_pkg::LINK_SCN_FIRST) &&
                    (link_sel <= bis_pkg::LINK_SCN_LAST);

  always_comb begin
    upd     = 1'b0;
    new_val = switch_val;
    if (ev_v) begin
      case (rx)
        3'(bis_pkg::RX_ON): begin
          upd     = 1'b1;
          new_val = 1'b1;
        end
        3'(bis_pkg::RX_OFF): begin
          upd     = 1'b1;
          new_val = 1'b0;
        end
        3'(bis_pkg::RX_TOG): begin
          upd     = 1'b1;
          new_val = link_out ? !link_status : !switch_val;
        end
        default: begin
          upd     = 1'b0;
          new_val = switch_val;
        end
      endcase
    end
  end

  // cyclic sending runs regardless of the block
  logic        cyc_stop_q;
  logic [15:0] cyc_cnt_q;
  logic        cyc_due;
  logic        cyc_match;
  logic        recover_send;

  assign cyc_match = (cyc_value_sel == bis_pkg::CYV_BOTH) ||
                     (cyc_value_sel == bis_pkg::CYV_ONE && switch_val) ||
                     (cyc_value_sel == bis_pkg::CYV_ZERO && !switch_val);
  assign cyc_due      = cyc_en && !cyc_stop_q && tick_s && (cyc_cnt_q <= 16'h0001);
  assign recover_send = cyc_en && bus_recover_evt;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_stop_q <= 1'b0;
      cyc_cnt_q  <= '0;
    end else begin
      if (upd || recover_send) begin
        cyc_cnt_q <= cyc_period;
      end else if (cyc_due) begin
        cyc_cnt_q <= cyc_period;
      end else if (cyc_en && tick_s && cyc_cnt_q != '0) begin
        cyc_cnt_q <= cyc_cnt_q - 16'h0001;
      end
      // a fresh update resumes cycling after a stop
      if (upd) begin
        cyc_stop_q <= 1'b0;
      end else if (ev_v && rx == 3'(bis_pkg::RX_TERM) && cyc_en) begin
        cyc_stop_q <= 1'b1;
      end
    end
  end

  // object value, telegram and event outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      switch_val  <= 1'b0;
      send_pulse  <= 1'b0;
      event_pulse <= 1'b0;
      event_id    <= 1'b0;
    end else begin
      if (upd) begin
        switch_val <= new_val;
      end
      send_pulse  <= upd || recover_send || (cyc_due && cyc_match);
      event_pulse <= ev_v;
      if (ev_v) begin
        event_id <= ev_id;
      end
    end
  end

  // internal connection to an output or a scenario pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_update <= 1'b0;
      out_index  <= '0;
      out_value  <= 1'b0;
      scen_trig  <= 1'b0;
      scen_num   <= '0;
    end else begin
      out_update <= upd && link_out;
      scen_trig  <= upd && link_scn;
      if (upd && link_out) begin
        out_index <= 4'(link_sel - bis_pkg::LINK_OUT_FIRST);
        out_value <= new_val;
      end
      if (upd && link_scn) begin
        // pair k gives 2k+1 on 0, 2k+2 on 1
        scen_num <= 5'({link_sel - bis_pkg::LINK_SCN_FIRST, 1'b0}) + 5'h01
                    + {4'h0, new_val};
      end
    end
  end

endmodule

// ===== dv/bis_contact_model.sv
// push-button contact that chatters after each change of level when bounces is not 0
`timescale 1ns/1ps
module bis_contact_model (
  input  wire logic       sys_clk,
  input  wire logic       level_cmd,
  input  wire logic [3:0] bounces,
  output logic            contact_in
);
  logic       lvl_q = 1'h0;
  logic [6:0] cnt_q = 7'h00;
  // chatter stays under the shortest debounce, else the sensor would see real edges
  always @(posedge sys_clk) begin
    lvl_q <= level_cmd;
    if (level_cmd != lvl_q) cnt_q <= {bounces, 3'h0};
    else if (cnt_q != 7'h00) cnt_q <= cnt_q - 7'h01;
  end
  assign contact_in = (cnt_q != 7'h00 && cnt_q[2]) ? ~lvl_q : lvl_q;
endmodule

// ===== dv/bis_switch_sensor_assertions.sv
// concurrent checks on the switch sensor ports
`timescale 1ns/1ps
module bis_switch_sensor_assertions #(
  parameter int TICK_MS_CYC = bis_pkg::MS_CYC
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       contact_in,
  input wire logic       int_block_en,
  input wire logic       block_obj_en,
  input wire logic       block_obj,
  input wire logic       inject_en,
  input wire logic       inject_valid,
  input wire logic       inject_value,
  input wire logic       long_en,
  input wire logic       min_sig_en,
  input wire logic       bus_recover_evt,
  input wire logic [2:0] react0,
  input wire logic       cyc_en,
  input wire logic [4:0] link_sel,
  input wire logic       link_status,
  input wire logic       switch_val,
  input wire logic       send_pulse,
  input wire logic       event_pulse,
  input wire logic       event_id,
  input wire logic       out_update,
  input wire logic [3:0] out_index,
  input wire logic       out_value,
  input wire logic       scen_trig,
  input wire logic [4:0] scen_num
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic blk;
  logic lnk_out;
  assign blk = int_block_en && block_obj_en && block_obj;
  assign lnk_out = link_sel >= 5'h01 && link_sel <= 5'h10;
  pulse_once_a: assert property (event_pulse |=> !event_pulse)
    else $error("event pulse longer than one cycle");
  plain_id_a: assert property (event_pulse && !long_en && !min_sig_en
    && !$past(inject_valid) |-> event_id == $past(contact_in))
    else $error("event id differs from contact level");
  block_in_a: assert property ($past(blk) && blk && !long_en && !min_sig_en
    |-> !event_pulse) else $error("event while input blocked");
  inject_ev_a: assert property (inject_en && inject_valid && !blk
    && !long_en && !min_sig_en |=> event_pulse && event_id == $past(inject_value))
    else $error("injection lost");
  out_link_a: assert property (out_update |-> lnk_out
    && out_index == 4'(link_sel - 5'h01) && out_value == switch_val)
    else $error("linked output update wrong");
  upd_link_a: assert property (send_pulse && event_pulse && lnk_out |-> out_update)
    else $error("linked output not updated");
  scen_num_a: assert property (scen_trig
    |-> scen_num == 5'(2 * (link_sel - 5'h11) + 1 + switch_val)) else $error("scenario number");
  tog_link_a: assert property (event_pulse && !event_id && react0 == 3'h2 && lnk_out
    |-> switch_val == !$past(link_status)) else $error("linked toggle value");
  min_hold_a: assert property (min_sig_en && $changed(contact_in)
    |=> !event_pulse [*8]) else $error("event before minimum signal time");
  long_wait_a: assert property (long_en && $rose(contact_in)
    |=> !event_pulse [*8]) else $error("event before press classified");
  rec_send_a: assert property (cyc_en && bus_recover_evt |=> send_pulse)
    else $error("no send after recovery");
endmodule
bind bis_switch_sensor bis_switch_sensor_assertions #(.TICK_MS_CYC(TICK_MS_CYC)) u_chk (
  .sys_clk, .reset, .contact_in, .int_block_en, .block_obj_en, .block_obj, .inject_en,
  .inject_valid, .inject_value, .long_en, .min_sig_en, .bus_recover_evt, .react0, .cyc_en,
  .link_sel, .link_status, .switch_val, .send_pulse, .event_pulse, .event_id, .out_update,
  .out_index, .out_value, .scen_trig, .scen_num);

// ===== dv/bis_switch_sensor_tb.sv
// self-checking bench for the switch sensor
`timescale 1ns/1ps
module bis_switch_sensor_tb;
  logic        sys_clk = 1'h0;
  logic        reset = 1'h1;
  logic        contact_in, level_cmd, int_block_en, block_obj_en, block_obj, inject_en;
  logic        inject_valid, inject_value, long_en, min_sig_en, rescan_en, cyc_en;
  logic        download_evt, bus_reset_evt, bus_recover_evt, link_status, sv, v;
  logic        switch_val, send_pulse, event_pulse, event_id, out_update, out_value, scen_trig;
  logic [2:0]  debounce_sel, react0, react1;
  logic [3:0]  bounces, out_index;
  logic [7:0]  long_time;
  logic [14:0] wait_time;
  logic [15:0] min_close_time, min_open_time, cyc_period;
  logic [1:0]  cyc_value_sel;
  logic [2:0]  nt;
  logic [4:0]  link_sel, scen_num;
  logic [2:0]  exp_q[$];
  int          n_fail = 0, comparisons = 0, n_cyc = 0, cyc_cnt = 0;

  always #10 sys_clk = ~sys_clk;
  bis_contact_model u_bis_contact_model (.sys_clk, .level_cmd, .bounces, .contact_in);
  bis_switch_sensor #(.TICK_MS_CYC(10)) u_bis_switch_sensor (.sys_clk, .reset, .contact_in,
    .int_block_en, .block_obj_en, .block_obj, .inject_en, .inject_valid, .inject_value,
    .debounce_sel, .long_en, .long_time, .min_sig_en, .min_close_time, .min_open_time,
    .rescan_en, .wait_time, .download_evt, .bus_reset_evt, .bus_recover_evt, .react0, .react1,
    .cyc_en, .cyc_period, .cyc_value_sel, .link_sel, .link_status, .switch_val, .send_pulse,
    .event_pulse, .event_id, .out_update, .out_index, .out_value, .scen_trig, .scen_num);

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (e !== s) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic press(input logic lv, input int hold, input bit ex);
    level_cmd <= lv;
    bounces <= 4'($urandom_range(9));
    if (ex) exp_q.push_back({lv, lv, 1'h1});
    cyc(hold);
  endtask
  task automatic inject(input logic iv, input logic [2:0] e);
    inject_valid <= 1'h1;
    inject_value <= iv;
    exp_q.push_back(e);
    cyc(1);
    inject_valid <= 1'h0;
    cyc(6);
  endtask
  task automatic rescan(input logic [2:0] p, input bit ex, input int hold);
    {download_evt, bus_reset_evt, bus_recover_evt} <= p;
    if (ex) exp_q.push_back(3'h1);
    cyc(1);
    {download_evt, bus_reset_evt, bus_recover_evt} <= 3'h0;
    cyc(hold);
  endtask

  // every event is matched against the oldest expectation
  always @(posedge sys_clk) begin
    if (!reset && send_pulse === 1'h1 && event_pulse !== 1'h1) n_cyc++;
    if (!reset && event_pulse === 1'h1) begin
      nt = (exp_q.size() != 0) ? exp_q.pop_front() : 3'hX;
      check("event", 16'(nt), 16'({event_id, switch_val, send_pulse}));
    end
  end
  // run is about 74000 cycles long
  always @(posedge sys_clk) if (++cyc_cnt == 95000) begin
    n_fail++;
    complete_run();
  end

  initial begin
    {level_cmd, bounces, int_block_en, block_obj_en, block_obj, inject_en, inject_valid} <= '0;
    {inject_value, debounce_sel, long_en, long_time, min_sig_en, rescan_en, wait_time} <= '0;
    {download_evt, bus_reset_evt, bus_recover_evt, cyc_en, link_sel, link_status} <= '0;
    {min_close_time, min_open_time} <= '0;
    react0 <= bis_pkg::RX_OFF;
    react1 <= bis_pkg::RX_ON;
    cyc_period <= 16'h0001;
    cyc_value_sel <= bis_pkg::CYV_BOTH;
    void'($urandom(32'h0A9F4750));
    cyc(10);
    reset <= 1'h0;
    cyc(2);
    repeat (4) begin
      press(1'h1, 300, 1'h1);
      press(1'h0, 300, 1'h1);
    end
    {int_block_en, block_obj_en, block_obj} <= 3'h7;
    press(1'h1, 300, 1'h0);
    press(1'h0, 300, 1'h0);
    int_block_en <= 1'h0;
    press(1'h1, 300, 1'h1);
    press(1'h0, 300, 1'h1);
    block_obj <= 1'h0;
    inject_en <= 1'h1;
    repeat (4) begin
      v = 1'($urandom);
      inject(v, {v, v, 1'h1});
    end
    sv = 1'h0;
    for (int r = 0; r < 5; r++) begin
      react1 <= 3'(r);
      case (r)
        0: sv = 1'h1;
        1: sv = 1'h0;
        2: sv = !sv;
        default: ;
      endcase
      inject(1'h1, {1'h1, sv, 1'(r < 3)});
    end
    react1 <= bis_pkg::RX_ON;
    link_sel <= 5'h05;
    react0 <= bis_pkg::RX_TOG;
    v = 1'($urandom);
    link_status <= v;
    inject(1'h0, {1'h0, !v, 1'h1});
    react0 <= bis_pkg::RX_OFF;
    for (int k = 0; k < 8; k++) begin
      link_sel <= 5'h11 + 5'(k);
      v = 1'($urandom);
      inject(v, {v, v, 1'h1});
    end
    link_sel <= 5'h00;
    for (int p = 1; p < 5; p = p * 2) rescan(3'(p), 1'h0, 20);
    rescan_en <= 1'h1;
    for (int p = 1; p < 5; p = p * 2) rescan(3'(p), 1'h1, 20);
    wait_time <= 15'h0001;
    rescan(3'h1, 1'h1, 10500);
    rescan_en <= 1'h0;
    long_en <= 1'h1;
    long_time <= 8'h01;
    press(1'h1, 400, 1'h0);
    press(1'h0, 400, 1'h1);
    press(1'h1, 3000, 1'h1);
    press(1'h0, 400, 1'h0);
    long_en <= 1'h0;
    min_sig_en <= 1'h1;
    min_close_time <= 16'h0002;
    min_open_time <= 16'h0001;
    press(1'h1, 2500, 1'h1);
    press(1'h0, 1500, 1'h1);
    press(1'h1, 500, 1'h0);
    press(1'h0, 1500, 1'h1);
    min_sig_en <= 1'h0;
    cyc_en <= 1'h1;
    rescan(3'h1, 1'h0, 5);
    {int_block_en, block_obj_en, block_obj} <= 3'h7;
    cyc_value_sel <= bis_pkg::CYV_ZERO;
    n_cyc = 0;
    cyc(25000);
    check("cyclic sends", 16'h0001, 16'(n_cyc >= 2 && n_cyc <= 3));
    // object holds 0, so a send-on-1 filter keeps the cycle quiet
    cyc_value_sel <= bis_pkg::CYV_ONE;
    n_cyc = 0;
    cyc(12000);
    check("filtered sends", 16'h0000, 16'(n_cyc));
    {int_block_en, block_obj_en, block_obj} <= 3'h0;
    cyc_value_sel <= bis_pkg::CYV_BOTH;
    react0 <= bis_pkg::RX_TERM;
    inject(1'h0, 3'h0);
    n_cyc = 0;
    cyc(12000);
    check("stopped sends", 16'h0000, 16'(n_cyc));
    check("left in queue", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule
